/* logic/split_screen_address_select.sv */
// Split-screen refresh start address selection with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "split_defines.svh"

// What this block does
// - Height is low byte plus two-bit high part
// - Height at or above panel lines: screen 1
// - Lines before height fetch from screen-1 start
// - Lines after height fetch from screen-2 start
// - Screen 1 always on top, any addresses
// - Identical start addresses are accepted
// - Screen-2 start is 17 bits, three registers
// - Screen 2 starts next line, left-most pixel
// - Landscape start is a word offset
// - Portrait mode never uses screen 2
// - Split may fall on any panel line
// - Screen-1 start is 17 bits, three registers
// - Pixels per word 16, 8, 4, 2
module split_screen_address_select
  import split_pkg::*;
#(
  parameter int ADDR_W = `SS_ADDR_W
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic      [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  input  wire logic              frame_start,
  input  wire logic              line_done,
  output logic      [ADDR_W-1:0] fetch_addr,
  output logic                   fetch_screen2,
  output logic      [4:0]        pixels_per_word
);

  initial
  begin
    if (ADDR_W != `SS_ADDR_W)
      $error("ADDR_W must be 17");
  end

  // Register file
  logic [7:0]  s1_lo, s1_mid, s2_lo, s2_mid, h_lo;
  logic        s1_hi, s2_hi;
  logic [1:0]  h_hi;
  logic [31:0] ctrl;
  logic [7:0]  next_s1_lo, next_s1_mid, next_s2_lo, next_s2_mid, next_h_lo;
  logic        next_s1_hi, next_s2_hi;
  logic [1:0]  next_h_hi;
  logic [31:0] next_ctrl;

  // Write channel state
  logic        aw_held, w_held, next_aw_held, next_w_held, next_bvalid;
  logic [5:0]  aw_idx, next_aw_idx;
  logic [31:0] w_data, next_w_data;
  logic        w_lane0, next_w_lane0;
  logic [1:0]  next_bresp;

  // Read channel state
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Derived values
  logic [`SS_LINE_W-1:0] height, panel_lines, line_count;
  logic [ADDR_W-1:0]     s1_addr, s2_addr, next_fetch_addr;
  logic                  portrait, next_fetch_screen2;
  depth_t                depth;
  screen_t               screen_sel;
  logic [4:0]            next_ppw;
  logic                  do_write;
  logic [5:0]            wr_idx;

  assign height      = {h_hi, h_lo};
  assign s1_addr     = {s1_hi, s1_mid, s1_lo};
  assign s2_addr     = {s2_hi, s2_mid, s2_lo};
  assign portrait    = ctrl[`SS_CTRL_PORT];
  assign depth       = depth_t'(ctrl[`SS_CTRL_BPP_HI:`SS_CTRL_BPP_LO]);
  assign panel_lines = ctrl[`SS_CTRL_PL_HI:`SS_CTRL_PL_LO];

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  assign do_write = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
  assign wr_idx   = aw_held ? aw_idx : s_axi_awaddr[7:2];

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_idx  = aw_idx;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_idx  = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      case (wr_idx)
        `SS_IDX_S1_LO, `SS_IDX_S1_MID, `SS_IDX_S1_HI, `SS_IDX_S2_LO, `SS_IDX_S2_MID,
        `SS_IDX_S2_HI, `SS_IDX_H_LO, `SS_IDX_H_HI, `SS_IDX_CTRL, `SS_IDX_STATUS:
          next_bresp = `SS_RESP_OKAY;
        default:
          next_bresp = `SS_RESP_SLVERR;
      endcase
    end
  end

  // Register updates; byte lane 0 carries every register, control also lanes 2 and 3
  always_comb
  begin
    logic [31:0] wd;
    logic        l0;
    wd          = (w_held) ? w_data : s_axi_wdata;
    l0          = (w_held) ? w_lane0 : s_axi_wstrb[0];
    next_s1_lo  = s1_lo;
    next_s1_mid = s1_mid;
    next_s1_hi  = s1_hi;
    next_s2_lo  = s2_lo;
    next_s2_mid = s2_mid;
    next_s2_hi  = s2_hi;
    next_h_lo   = h_lo;
    next_h_hi   = h_hi;
    next_ctrl   = ctrl;
    if (do_write)
    begin
      case (wr_idx)
        `SS_IDX_S1_LO:  if (l0) next_s1_lo = wd[7:0];
        `SS_IDX_S1_MID: if (l0) next_s1_mid = wd[7:0];
        `SS_IDX_S1_HI:  if (l0) next_s1_hi = wd[0];
        `SS_IDX_S2_LO:  if (l0) next_s2_lo = wd[7:0];
        `SS_IDX_S2_MID: if (l0) next_s2_mid = wd[7:0];
        `SS_IDX_S2_HI:  if (l0) next_s2_hi = wd[0];
        `SS_IDX_H_LO:   if (l0) next_h_lo = wd[7:0];
        `SS_IDX_H_HI:   if (l0) next_h_hi = wd[1:0];
        `SS_IDX_CTRL:
        begin
          if (l0) next_ctrl[2:0] = wd[2:0];
          if (s_axi_wstrb[2] || w_held) next_ctrl[23:16] = wd[23:16];
          if (s_axi_wstrb[3] || w_held) next_ctrl[25:24] = wd[25:24];
        end
        default:        next_ctrl = ctrl;
      endcase
    end
  end

  always_comb
  begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = `SS_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      case (s_axi_araddr[7:2])
        `SS_IDX_S1_LO:  next_rdata[7:0] = s1_lo;
        `SS_IDX_S1_MID: next_rdata[7:0] = s1_mid;
        `SS_IDX_S1_HI:  next_rdata[0] = s1_hi;
        `SS_IDX_S2_LO:  next_rdata[7:0] = s2_lo;
        `SS_IDX_S2_MID: next_rdata[7:0] = s2_mid;
        `SS_IDX_S2_HI:  next_rdata[0] = s2_hi;
        `SS_IDX_H_LO:   next_rdata[7:0] = h_lo;
        `SS_IDX_H_HI:   next_rdata[1:0] = h_hi;
        `SS_IDX_CTRL:   next_rdata = {6'h00, ctrl[25:0]};
        `SS_IDX_STATUS:
        begin
          next_rdata[`SS_LINE_W-1:0] = line_count;
          next_rdata[`SS_STAT_SCR2] = fetch_screen2;
          next_rdata[`SS_STAT_PPW_HI:`SS_STAT_PPW_LO] = pixels_per_word;
        end
        default:        next_rresp = `SS_RESP_SLVERR;
      endcase
    end
  end

  split_line_counter #(.LINE_W(`SS_LINE_W)) u_lines
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .frame_start (frame_start),
    .line_done   (line_done),
    .height      (height),
    .panel_lines (panel_lines),
    .portrait    (portrait),
    .line_count  (line_count),
    .screen_sel  (screen_sel)
  );

  // Start address of the active region; same value in both is fine
  always_comb
  begin
    next_fetch_screen2 = (screen_sel == SCR_BOTTOM) && !portrait;
    next_fetch_addr    = next_fetch_screen2 ? s2_addr : s1_addr;
    case (depth)
      BPP_1:   next_ppw = 5'h10;
      BPP_2:   next_ppw = 5'h08;
      BPP_4:   next_ppw = 5'h04;
      BPP_8:   next_ppw = 5'h02;
      default: next_ppw = 5'h10;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_lo           <= `SS_BYTE_RST;
      s1_mid          <= `SS_BYTE_RST;
      s1_hi           <= 1'b0;
      s2_lo           <= `SS_BYTE_RST;
      s2_mid          <= `SS_BYTE_RST;
      s2_hi           <= 1'b0;
      h_lo            <= `SS_BYTE_RST;
      h_hi            <= 2'b00;
      ctrl            <= `SS_CTRL_RST;
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_idx          <= 6'h00;
      w_data          <= 32'h0000_0000;
      w_lane0         <= 1'b0;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= `SS_RESP_OKAY;
      s_axi_rvalid    <= 1'b0;
      s_axi_rdata     <= 32'h0000_0000;
      s_axi_rresp     <= `SS_RESP_OKAY;
      fetch_addr      <= '0;
      fetch_screen2   <= 1'b0;
      pixels_per_word <= 5'h10;
    end
    else if (ce)
    begin
      s1_lo           <= next_s1_lo;
      s1_mid          <= next_s1_mid;
      s1_hi           <= next_s1_hi;
      s2_lo           <= next_s2_lo;
      s2_mid          <= next_s2_mid;
      s2_hi           <= next_s2_hi;
      h_lo            <= next_h_lo;
      h_hi            <= next_h_hi;
      ctrl            <= next_ctrl;
      aw_held         <= next_aw_held;
      w_held          <= next_w_held;
      aw_idx          <= next_aw_idx;
      w_data          <= next_w_data;
      w_lane0         <= next_w_lane0;
      s_axi_bvalid    <= next_bvalid;
      s_axi_bresp     <= next_bresp;
      s_axi_rvalid    <= next_rvalid;
      s_axi_rdata     <= next_rdata;
      s_axi_rresp     <= next_rresp;
      fetch_addr      <= next_fetch_addr;
      fetch_screen2   <= next_fetch_screen2;
      pixels_per_word <= next_ppw;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence cfg_still;
    $past(aresetn) && $past(ce) && $stable(height) && $stable(panel_lines) && $stable(portrait);
  endsequence

  sequence frame_begins;
    ce && frame_start;
  endsequence

  sequence line_counted;
    ce && line_done && !frame_start && line_count != 10'h3FF;
  endsequence

  frame_restart_a: assert property (frame_begins |=> line_count == 10'h000)
    else $error("line count not cleared at frame start");

  line_step_a: assert property (line_counted |=> line_count == $past(line_count) + 10'h001)
    else $error("line count did not advance");

  top_region_a: assert property (cfg_still ##0 (line_count < height)
    |-> screen_sel == SCR_TOP)
    else $error("screen 2 selected above the split");

  bottom_region_a: assert property (cfg_still ##0 (!portrait && height < panel_lines
    && line_count >= height) |-> screen_sel == SCR_BOTTOM)
    else $error("screen 2 not selected below the split");

  full_screen1_a: assert property (cfg_still ##0 (height >= panel_lines)
    |-> screen_sel == SCR_TOP)
    else $error("split shown with height beyond panel");

  portrait_off_a: assert property (ce && portrait ##1 ce |=> !fetch_screen2)
    else $error("screen 2 used in portrait mode");

  addr_pick_a: assert property (ce && next_fetch_screen2 |=> fetch_addr == $past(s2_addr))
    else $error("screen 2 start address not fetched");

  ppw_map_a: assert property (ce && depth == BPP_1 |=> pixels_per_word == 5'h10)
    else $error("pixels per word wrong at one bit per pixel");

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");

endmodule : split_screen_address_select

/* inc/split_defines.svh */
// Register indices, field positions and reset values of the split-screen selector
`ifndef SPLIT_DEFINES_SVH
`define SPLIT_DEFINES_SVH

`define SS_IDX_S1_LO    6'h0C
`define SS_IDX_S1_MID   6'h0D
`define SS_IDX_S2_LO    6'h0E
`define SS_IDX_S2_MID   6'h0F
`define SS_IDX_S1_HI    6'h10
`define SS_IDX_H_LO     6'h13
`define SS_IDX_H_HI     6'h14
`define SS_IDX_S2_HI    6'h20
`define SS_IDX_CTRL     6'h21
`define SS_IDX_STATUS   6'h22

`define SS_ADDR_W       17
`define SS_LINE_W       10
`define SS_BYTE_RST     8'h00
`define SS_CTRL_RST     32'h00F0_0006
`define SS_CTRL_PORT    0
`define SS_CTRL_BPP_LO  1
`define SS_CTRL_BPP_HI  2
`define SS_CTRL_PL_LO   16
`define SS_CTRL_PL_HI   25
`define SS_STAT_SCR2    16
`define SS_STAT_PPW_LO  24
`define SS_STAT_PPW_HI  28

`define SS_RESP_OKAY    2'b00
`define SS_RESP_SLVERR  2'b10

`endif

/* inc/split_pkg.sv */
// Types shared by the split-screen selector
package split_pkg;

  typedef enum logic [1:0]
  {
    SCR_TOP    = 2'b01,
    SCR_BOTTOM = 2'b10
  } screen_t;

  typedef enum logic [1:0]
  {
    BPP_1 = 2'b00,
    BPP_2 = 2'b01,
    BPP_4 = 2'b10,
    BPP_8 = 2'b11
  } depth_t;

endpackage : split_pkg

/* logic/split_line_counter.sv */
// Scan-line counter and screen region selection
`timescale 1ns/1ns
`include "split_defines.svh"

module split_line_counter
  import split_pkg::*;
#(
  parameter int LINE_W = `SS_LINE_W
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              frame_start,
  input  wire logic              line_done,
  input  wire logic [LINE_W-1:0] height,
  input  wire logic [LINE_W-1:0] panel_lines,
  input  wire logic              portrait,
  output logic      [LINE_W-1:0] line_count,
  output screen_t                screen_sel
);

  initial
  begin
    if (LINE_W < 1 || LINE_W > 16)
      $error("LINE_W out of range");
  end

  logic [LINE_W-1:0] next_line_count;
  screen_t           next_screen_sel;

  always_comb
  begin
    next_line_count = line_count;
    if (frame_start)
      next_line_count = '0;
    else if (line_done && line_count != {LINE_W{1'b1}})
      next_line_count = line_count + {{(LINE_W-1){1'b0}}, 1'b1};
    // Lower region only when landscape and the split falls on the panel
    if (!portrait && height < panel_lines && next_line_count >= height)
      next_screen_sel = SCR_BOTTOM;
    else
      next_screen_sel = SCR_TOP;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_count <= '0;
      screen_sel <= SCR_TOP;
    end
    else if (ce)
    begin
      line_count <= next_line_count;
      screen_sel <= next_screen_sel;
    end
  end

endmodule : split_line_counter

/* sim/panel_refresh_model.sv */
// Panel-side refresh pacing model: frame start then a burst of line pulses
`timescale 1ns/1ns

module panel_refresh_model
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic [9:0] lines,
  input  wire logic       slow,
  output logic            frame_start,
  output logic            line_done,
  output logic            busy
);
  logic [9:0] left;
  logic [1:0] gap;

  always_ff @(posedge aclk)
  begin
    frame_start <= 1'b0;
    line_done   <= 1'b0;
    if (!aresetn)
    begin
      busy <= 1'b0;
      left <= 10'h000;
      gap  <= 2'h0;
    end
    else if (start && !busy)
    begin
      frame_start <= 1'b1;
      busy        <= 1'b1;
      left        <= lines;
      gap         <= slow ? 2'h3 : 2'h0;
    end
    else if (busy)
    begin
      // Slow panel leaves idle cycles between lines
      if (gap != 2'h0)
        gap <= gap - 2'h1;
      else if (left == 10'h000)
        busy <= 1'b0;
      else
      begin
        line_done <= 1'b1;
        left      <= left - 10'h001;
        gap       <= slow ? 2'h3 : 2'h0;
      end
    end
  end
endmodule : panel_refresh_model

/* sim/test_split_screen_address_select.sv */
// Self-checking bench of the split-screen start address selector
`timescale 1ns/1ns
`include "split_defines.svh"

module test_split_screen_address_select
  import split_pkg::*;
;
  logic        aclk, aresetn, ce, start, slow, frame_start, line_done, busy;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, fetch_screen2;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [9:0]  lines;
  logic [16:0] fetch_addr;
  logic [4:0]  pixels_per_word;
  int          fail_count, total_checks;

  split_screen_address_select i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .frame_start(frame_start), .line_done(line_done), .fetch_addr(fetch_addr),
    .fetch_screen2(fetch_screen2), .pixels_per_word(pixels_per_word));

  panel_refresh_model i_panel (.aclk(aclk), .aresetn(aresetn), .start(start), .lines(lines),
    .slow(slow), .frame_start(frame_start), .line_done(line_done), .busy(busy));

  always #50 aclk = ~aclk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] ad(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : ad

  function automatic logic [31:0] ctl(input logic [9:0] pl, input logic [1:0] dp, input logic pt);
    return {6'h00, pl, 13'h0000, dp, pt};
  endfunction : ctl

  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= ad(idx);
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk({31'h0, bvalid}, 32'h1, "write answer");
    chk({30'h0, bresp}, {30'h0, er}, "write response");
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= ad(idx);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    chk({31'h0, rvalid}, 32'h1, "read answer");
    chk({30'h0, rresp}, {30'h0, er}, "read response");
    chk(rdata, exp, "read data");
  endtask : rd

  task automatic setup(input logic [16:0] s1, input logic [16:0] s2, input logic [9:0] h,
                       input logic [31:0] c);
    wr(`SS_IDX_S1_LO, {24'h0, s1[7:0]}, `SS_RESP_OKAY);
    wr(`SS_IDX_S1_MID, {24'h0, s1[15:8]}, `SS_RESP_OKAY);
    wr(`SS_IDX_S1_HI, {31'h0, s1[16]}, `SS_RESP_OKAY);
    wr(`SS_IDX_S2_LO, {24'h0, s2[7:0]}, `SS_RESP_OKAY);
    wr(`SS_IDX_S2_MID, {24'h0, s2[15:8]}, `SS_RESP_OKAY);
    wr(`SS_IDX_S2_HI, {31'h0, s2[16]}, `SS_RESP_OKAY);
    wr(`SS_IDX_H_LO, {24'h0, h[7:0]}, `SS_RESP_OKAY);
    wr(`SS_IDX_H_HI, {30'h0, h[9:8]}, `SS_RESP_OKAY);
    wr(`SS_IDX_CTRL, c, `SS_RESP_OKAY);
  endtask : setup

  // One frame of n lines, then the region of the line after the last one
  task automatic frame(input int n, input logic sl, input logic s2, input logic [16:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    lines <= n[9:0];
    slow  <= sl;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    do
    begin
      @(posedge aclk);
      k++;
    end
    while (busy !== 1'b0 && k < 5000);
    chk({31'h0, busy}, 32'h0, "frame end");
    repeat (4) @(posedge aclk);
    chk({31'h0, fetch_screen2}, {31'h0, s2}, "screen select");
    chk({15'h0, fetch_addr}, {15'h0, a}, "fetch address");
  endtask : frame

  task automatic t_reset;
    rd(`SS_IDX_CTRL, `SS_CTRL_RST, `SS_RESP_OKAY);
    rd(`SS_IDX_S2_LO, 32'h0, `SS_RESP_OKAY);
    rd(6'h3F, 32'h0, `SS_RESP_SLVERR);
    wr(6'h3F, 32'hFFFF_FFFF, `SS_RESP_SLVERR);
    chk({27'h0, pixels_per_word}, 32'h2, "reset depth");
  endtask : t_reset

  task automatic t_split;
    setup(17'h1ABCD, 17'h00123, 10'h102, ctl(10'h300, 2'h2, 1'b0));
    rd(`SS_IDX_H_HI, 32'h1, `SS_RESP_OKAY);
    frame(257, 1'b0, 1'b0, 17'h1ABCD);
    frame(258, 1'b1, 1'b1, 17'h00123);
    frame(0, 1'b0, 1'b0, 17'h1ABCD);
    rd(`SS_IDX_STATUS, {3'h0, 5'h04, 24'h0}, `SS_RESP_OKAY);
    // Clock enable low: a whole frame must leave count and region untouched
    ce <= 1'b0;
    frame(300, 1'b0, 1'b0, 17'h1ABCD);
    ce <= 1'b1;
    rd(`SS_IDX_STATUS, {3'h0, 5'h04, 24'h0}, `SS_RESP_OKAY);
  endtask : t_split

  task automatic t_full;
    setup(17'h00040, 17'h00800, 10'h0F0, ctl(10'h0F0, 2'h0, 1'b0));
    frame(240, 1'b0, 1'b0, 17'h00040);
    wr(`SS_IDX_H_LO, 32'hEF, `SS_RESP_OKAY);
    frame(239, 1'b1, 1'b1, 17'h00800);
  endtask : t_full

  task automatic t_same;
    setup(17'h1ABCD, 17'h1ABCD, 10'h003, ctl(10'h0F0, 2'h1, 1'b0));
    rd(`SS_IDX_S2_HI, 32'h1, `SS_RESP_OKAY);
    rd(`SS_IDX_S2_MID, 32'hAB, `SS_RESP_OKAY);
    frame(5, 1'b0, 1'b1, 17'h1ABCD);
  endtask : t_same

  task automatic t_portrait;
    setup(17'h00010, 17'h00900, 10'h003, ctl(10'h0F0, 2'h3, 1'b1));
    frame(5, 1'b0, 1'b0, 17'h00010);
  endtask : t_portrait

  task automatic t_depth;
    for (int d = 0; d < 4; d++)
    begin
      wr(`SS_IDX_CTRL, ctl(10'h0F0, d[1:0], 1'b0), `SS_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk({27'h0, pixels_per_word}, 32'd16 >> d, "pixels per word");
    end
  endtask : t_depth

  initial
  begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    finish_test();
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, start, slow} = 7'h00;
    {awaddr, araddr, wstrb, lines} = 30'h0;
    wdata = 32'h0;
    fail_count = 0;
    total_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_split();
    t_full();
    t_same();
    t_portrait();
    t_depth();
    finish_test();
  end
endmodule : test_split_screen_address_select
